// ---- asc_pkg.sv ----
// constants, types and register map of the converter sequence control
`default_nettype none
package asc_pkg;

  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] ASC_CTRL1_ADDR = 8'hb4;
  localparam logic [7:0] ASC_CTRL2_ADDR = 8'hb5;
  localparam logic [7:0] ASC_RES_LO_ADDR = 8'hba;
  localparam logic [7:0] ASC_RES_HI_ADDR = 8'hbb;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int ASC_DONE_BIT = 7;
  localparam int ASC_GO_BIT = 6;
  localparam int ASC_TRIG_LSB = 4;
  localparam int ASC_RNG_LSB = 2;
  localparam int ASC_RSV_LSB = 0;
  localparam int ASC_REF_LSB = 6;
  localparam int ASC_DEC_LSB = 4;
  localparam int ASC_CH_LSB = 0;
  localparam int ASC_RES_LO_LSB = 2;

  // ---------------------------------------------------------------
  // values after reset
  // ---------------------------------------------------------------
  localparam logic [1:0] ASC_TRIG_RST = 2'h3;
  localparam logic [1:0] ASC_RNG_RST = 2'h0;
  localparam logic [1:0] ASC_RSV_RST = 2'h3;
  localparam logic [1:0] ASC_REF_RST = 2'h0;
  localparam logic [1:0] ASC_DEC_RST = 2'h1;
  localparam logic [3:0] ASC_CH_RST = 4'h0;
  localparam logic [13:0] ASC_RES_RST = 14'h0000;

  // ---------------------------------------------------------------
  // timing, in core clocks and converter clocks
  // ---------------------------------------------------------------
  localparam int ASC_CONV_CLK_DIV = 6;
  localparam int ASC_CNT_W = 10;
  localparam logic [9:0] ASC_SETTLE_CYC = 10'h010;
  localparam logic [9:0] ASC_DEC_BASE = 10'h040;

  // ---------------------------------------------------------------
  // channel ranges and resolution masks
  // ---------------------------------------------------------------
  localparam logic [3:0] ASC_LAST_SE_CH = 4'h7;
  localparam logic [3:0] ASC_FIRST_DIFF_CH = 4'h8;
  localparam logic [3:0] ASC_LAST_DIFF_CH = 4'hb;
  localparam logic [13:0] ASC_MASK_8B = 14'h3fc0;
  localparam logic [13:0] ASC_MASK_10B = 14'h3ff0;
  localparam logic [13:0] ASC_MASK_12B = 14'h3ffc;
  localparam logic [13:0] ASC_MASK_13B = 14'h3ffe;

  // ---------------------------------------------------------------
  // enumerations
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ASC_TRIG_EXT = 2'h0,
    ASC_TRIG_FREE = 2'h1,
    ASC_TRIG_TIMER = 2'h2,
    ASC_TRIG_GO = 2'h3
  } asc_trig_e;

  typedef enum logic [1:0] {
    ASC_RNG_NORMAL = 2'h0,
    ASC_RNG_STEP = 2'h1,
    ASC_RNG_SEED = 2'h2,
    ASC_RNG_STOP = 2'h3
  } asc_rng_e;

  typedef enum logic [1:0] {
    ASC_ST_IDLE = 2'b01,
    ASC_ST_CONV = 2'b10
  } asc_state_e;

endpackage
`default_nettype wire

// ---- asc_tick_div.sv ----
// converter clock enable: one pulse every DIV core clocks
`timescale 1ns/1ps
`default_nettype none
module asc_tick_div #(
  parameter int DIV = 6
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // converter clock tick
  output logic tick
);

  typedef struct packed {
    logic [3:0] cnt;
    logic tick;
  } asc_div_s;

  asc_div_s s_q, s_d;

  always_comb begin
    s_d = s_q;
    s_d.tick = 1'b0;
    if (s_q.cnt == 4'(DIV - 1)) begin
      s_d.cnt = 4'h0;
      s_d.tick = 1'b1;
    end else begin
      s_d.cnt = s_q.cnt + 4'h1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tick = s_q.tick;

endmodule // asc_tick_div
`default_nettype wire

// ---- asc_seq_ctrl.sv ----
// converter sequence control: registers, triggers, sequencing, timing
//
// Functional notes
// R1 - high result byte holds bits 13:6
// R2 - done flag clears after both bytes read
// R3 - done flag stays high on overrun
// R4 - go bit starts when trigger go, idle
// R5 - trigger select chooses sequence start event
// R6 - random control field drives generator mode
// R7 - step and seed requests return to normal
// R8 - seeding waits for running converter
// R9 - software writes ones to reserved bits
// R10 - reference select drives sequence reference
// R11 - decimation select sets rate and resolution
// R12 - conversion length follows decimation rate
// R13 - last channel defines sequence range
// R14 - channel read returns result's channel
// R15 - low byte holds bits 5:0, zeros
// R16 - converter clock is core clock over six
// R17 - conversion lasts decimation plus sixteen ticks
// R18 - each sequence conversion raises dma trigger
// R19 - unused low result bits read zero
`timescale 1ns/1ps
`default_nettype none
module asc_seq_ctrl (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // start events
  input wire logic external_trigger_pin,
  input wire logic timer1_ch1_high,
  // analog front end
  input wire logic [13:0] conv_result,
  output logic conv_start,
  output logic conv_active,
  output logic [3:0] mux_channel,
  output logic [1:0] seq_ref,
  output logic [1:0] seq_dec,
  // dma triggers
  output logic dma_all,
  output logic [7:0] dma_chan,
  // random generator
  input wire logic rng_seed_done,
  output logic [1:0] rng_mode,
  output logic rng_step,
  output logic rng_seed_req
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    asc_pkg::asc_state_e st;
    logic [9:0] cnt;
    logic [3:0] ch;
    logic [1:0] trig;
    logic go;
    logic [1:0] rng;
    logic [1:0] rsv;
    logic [1:0] refsel;
    logic [1:0] dec;
    logic [3:0] sch_end;
    logic [13:0] res;
    logic [3:0] res_ch;
    logic done;
    logic hi_rd;
    logic lo_rd;
    logic [7:0] rdata;
    logic ext_prev;
    logic dma_all;
    logic [7:0] dma_ch;
    logic rng_step;
    logic rng_seed;
    logic conv_start;
    logic active;
  } asc_state_s;

  asc_state_s s_q, s_d;
  logic tick;

  asc_tick_div #(
    .DIV(asc_pkg::ASC_CONV_CLK_DIV)
  ) u_tick_div (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .tick(tick) // R16
  );

  // ---------------------------------------------------------------
  // decoded helpers
  // ---------------------------------------------------------------
  logic [9:0] conv_len;
  logic [13:0] res_mask;
  logic [3:0] first_ch;
  logic wr_c1, wr_c2, rd_hi, rd_lo;
  logic start_ev, conv_end, seq_end;

  always_comb begin
    // sixteen settling ticks plus the decimation rate
    conv_len = (asc_pkg::ASC_DEC_BASE << s_q.dec)
      + asc_pkg::ASC_SETTLE_CYC; // R12 R17
    unique case (s_q.dec)
      2'h0: res_mask = asc_pkg::ASC_MASK_8B; // R11 R19
      2'h1: res_mask = asc_pkg::ASC_MASK_10B;
      2'h2: res_mask = asc_pkg::ASC_MASK_12B;
      2'h3: res_mask = asc_pkg::ASC_MASK_13B;
    endcase
    // R13
    if (s_q.sch_end <= asc_pkg::ASC_LAST_SE_CH) begin
      first_ch = 4'h0;
    end else if (s_q.sch_end <= asc_pkg::ASC_LAST_DIFF_CH) begin
      first_ch = asc_pkg::ASC_FIRST_DIFF_CH;
    end else begin
      first_ch = s_q.sch_end;
    end
    wr_c1 = reg_wr && (reg_addr == asc_pkg::ASC_CTRL1_ADDR);
    wr_c2 = reg_wr && (reg_addr == asc_pkg::ASC_CTRL2_ADDR);
    rd_hi = reg_rd && (reg_addr == asc_pkg::ASC_RES_HI_ADDR);
    rd_lo = reg_rd && (reg_addr == asc_pkg::ASC_RES_LO_ADDR);
    conv_end = (s_q.st == asc_pkg::ASC_ST_CONV) && tick
      && (s_q.cnt == conv_len - 10'h001); // R17
    // >= also ends a run whose end was lowered mid-run
    seq_end = conv_end && (s_q.ch >= s_q.sch_end);
    // R5
    unique case (s_q.trig)
      asc_pkg::ASC_TRIG_EXT:
        start_ev = external_trigger_pin && !s_q.ext_prev;
      asc_pkg::ASC_TRIG_FREE: start_ev = 1'b1;
      asc_pkg::ASC_TRIG_TIMER: start_ev = timer1_ch1_high;
      asc_pkg::ASC_TRIG_GO: start_ev = s_q.go; // R4
    endcase
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.ext_prev = external_trigger_pin;
    s_d.conv_start = 1'b0;
    s_d.dma_all = 1'b0;
    s_d.dma_ch = 8'h00;
    s_d.rng_step = 1'b0;

    // sequencer
    unique case (s_q.st)
      asc_pkg::ASC_ST_IDLE: begin
        if (start_ev) begin
          s_d.st = asc_pkg::ASC_ST_CONV;
          s_d.ch = first_ch; // R13
          s_d.cnt = 10'h000;
          s_d.conv_start = 1'b1;
        end
      end
      asc_pkg::ASC_ST_CONV: begin
        if (tick) begin
          s_d.cnt = s_q.cnt + 10'h001;
        end
        if (conv_end) begin
          s_d.res = conv_result & res_mask; // R19
          s_d.res_ch = s_q.ch; // R14
          s_d.dma_all = 1'b1; // R18
          if (s_q.ch <= asc_pkg::ASC_LAST_SE_CH) begin
            s_d.dma_ch = 8'h01 << s_q.ch[2:0]; // R18
          end
          if (seq_end) begin
            s_d.go = 1'b0; // R4
            s_d.st = asc_pkg::ASC_ST_IDLE;
          end else begin
            s_d.ch = s_q.ch + 4'h1;
            s_d.cnt = 10'h000;
            s_d.conv_start = 1'b1;
          end
        end
      end
      default: begin
        // illegal one-hot code: back to idle, no run pending
        s_d.st = asc_pkg::ASC_ST_IDLE;
        s_d.go = 1'b0;
      end
    endcase
    s_d.active = (s_d.st == asc_pkg::ASC_ST_CONV);

    // -----------------------------------------------------------
    // done flag: both bytes read clears, a new result sets and wins
    // -----------------------------------------------------------
    if (rd_hi) begin
      s_d.hi_rd = 1'b1;
    end
    if (rd_lo) begin
      s_d.lo_rd = 1'b1;
    end
    if (s_d.hi_rd && s_d.lo_rd) begin
      s_d.done = 1'b0; // R2
      s_d.hi_rd = 1'b0;
      s_d.lo_rd = 1'b0;
    end
    if (conv_end) begin
      s_d.done = 1'b1; // R2 R3
      s_d.hi_rd = 1'b0;
      s_d.lo_rd = 1'b0;
    end

    // -----------------------------------------------------------
    // random generator requests
    // -----------------------------------------------------------
    if (s_q.rng == asc_pkg::ASC_RNG_STEP) begin
      s_d.rng_step = 1'b1; // R6
      s_d.rng = asc_pkg::ASC_RNG_NORMAL; // R7
    end
    // seeding only while the modulator runs
    // next state, so the request drops with the last conversion
    s_d.rng_seed = (s_q.rng == asc_pkg::ASC_RNG_SEED)
      && (s_d.st == asc_pkg::ASC_ST_CONV); // R8
    if (s_q.rng_seed && rng_seed_done) begin
      s_d.rng = asc_pkg::ASC_RNG_NORMAL; // R7
      s_d.rng_seed = 1'b0;
    end

    // -----------------------------------------------------------
    // register writes
    // -----------------------------------------------------------
    if (wr_c1) begin
      s_d.trig = reg_wdata[asc_pkg::ASC_TRIG_LSB +: 2];
      s_d.rng = reg_wdata[asc_pkg::ASC_RNG_LSB +: 2]; // R6
      s_d.rsv = reg_wdata[asc_pkg::ASC_RSV_LSB +: 2];
      // go accepted only when selected and nothing runs
      if (reg_wdata[asc_pkg::ASC_GO_BIT]
          && (reg_wdata[asc_pkg::ASC_TRIG_LSB +: 2]
              == asc_pkg::ASC_TRIG_GO)
          && (s_q.st == asc_pkg::ASC_ST_IDLE) && !s_q.go) begin
        s_d.go = 1'b1; // R4
      end
    end
    if (wr_c2) begin
      s_d.refsel = reg_wdata[asc_pkg::ASC_REF_LSB +: 2]; // R10
      s_d.dec = reg_wdata[asc_pkg::ASC_DEC_LSB +: 2]; // R11
      s_d.sch_end = reg_wdata[asc_pkg::ASC_CH_LSB +: 4]; // R13
    end

    // -----------------------------------------------------------
    // register reads, data in the following cycle only
    // -----------------------------------------------------------
    s_d.rdata = 8'h00;
    if (reg_rd) begin
      unique case (reg_addr)
        asc_pkg::ASC_CTRL1_ADDR:
          s_d.rdata = {s_q.done, s_q.go, s_q.trig, s_q.rng, s_q.rsv};
        asc_pkg::ASC_CTRL2_ADDR:
          s_d.rdata = {s_q.refsel, s_q.dec, s_q.res_ch}; // R14
        asc_pkg::ASC_RES_LO_ADDR:
          s_d.rdata = {s_q.res[5:0], 2'b00}; // R15
        asc_pkg::ASC_RES_HI_ADDR:
          s_d.rdata = s_q.res[13:6]; // R1
        default: s_d.rdata = 8'h00;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      s_q <= '0;
      s_q.st <= asc_pkg::ASC_ST_IDLE;
      s_q.trig <= asc_pkg::ASC_TRIG_RST;
      s_q.rng <= asc_pkg::ASC_RNG_RST;
      s_q.rsv <= asc_pkg::ASC_RSV_RST; // R9
      s_q.refsel <= asc_pkg::ASC_REF_RST;
      s_q.dec <= asc_pkg::ASC_DEC_RST;
      s_q.sch_end <= asc_pkg::ASC_CH_RST;
      s_q.res_ch <= asc_pkg::ASC_CH_RST;
      s_q.res <= asc_pkg::ASC_RES_RST; // R1
    end else begin
      s_q <= s_d;
    end
  end

  // ---------------------------------------------------------------
  // outputs, all from flip-flops
  // ---------------------------------------------------------------
  assign reg_rdata = s_q.rdata;
  assign conv_start = s_q.conv_start;
  assign conv_active = s_q.active;
  assign mux_channel = s_q.ch;
  assign seq_ref = s_q.refsel; // R10
  assign seq_dec = s_q.dec; // R11
  assign dma_all = s_q.dma_all;
  assign dma_chan = s_q.dma_ch;
  assign rng_mode = s_q.rng; // R6
  assign rng_step = s_q.rng_step;
  assign rng_seed_req = s_q.rng_seed; // R8

endmodule // asc_seq_ctrl
`default_nettype wire

// ---- asc_seq_ctrl_chk.sv ----
// port checker for the converter sequence control
`timescale 1ns/1ps
`default_nettype none
module asc_seq_ctrl_chk (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // converter side
  input wire logic conv_start,
  input wire logic conv_active,
  input wire logic [1:0] seq_ref,
  input wire logic [1:0] seq_dec,
  input wire logic dma_all,
  input wire logic [7:0] dma_chan,
  input wire logic [1:0] rng_mode,
  input wire logic rng_step,
  input wire logic rng_seed_req
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // ----------------------------------------------------------------
  // sequences
  // ----------------------------------------------------------------
  sequence busy_run;
    conv_active [*8];
  endsequence
  sequence ctrl2_wr;
    reg_wr && reg_addr == asc_pkg::ASC_CTRL2_ADDR;
  endsequence
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside read cycle");
  chan_onehot_a: assert property (
    dma_chan != 8'h00 |-> dma_all && $onehot(dma_chan))
    else $error("channel trigger without common trigger");
  dma_cause_a: assert property (dma_all |-> $past(conv_active))
    else $error("trigger without a running conversion");
  seed_idle_a: assert property (rng_seed_req |-> conv_active)
    else $error("seed requested while converter idle");
  step_norm_a: assert property (
    rng_step |-> rng_mode == 2'h0 ##1 !rng_step)
    else $error("step pulse wrong");
  start_active_a: assert property (conv_start |-> conv_active)
    else $error("start without active");
  busy_min_a: assert property ($rose(conv_active) |-> busy_run)
    else $error("conversion too short");
  ref_follow_a: assert property (
    ctrl2_wr |=> seq_ref == $past(reg_wdata[7:6]))
    else $error("reference select not applied");
  dec_follow_a: assert property (
    ctrl2_wr |=> seq_dec == $past(reg_wdata[5:4]))
    else $error("decimation select not applied");
endmodule // asc_seq_ctrl_chk
bind asc_seq_ctrl asc_seq_ctrl_chk u_asc_seq_ctrl_chk (.core_clk(core_clk),
  .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .conv_start(conv_start),
  .conv_active(conv_active), .seq_ref(seq_ref), .seq_dec(seq_dec),
  .dma_all(dma_all), .dma_chan(dma_chan), .rng_mode(rng_mode),
  .rng_step(rng_step), .rng_seed_req(rng_seed_req));
`default_nettype wire

// ---- asc_fe_model.sv ----
// analog front end model: result word and seed completion
`timescale 1ns/1ps
`default_nettype none
module asc_fe_model (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // converter side
  input wire logic conv_active,
  input wire logic rng_seed_req,
  output logic [13:0] conv_result,
  output logic rng_seed_done
);
  logic [2:0] seed_cnt;
  // idle result is inverted so a stale value never looks valid
  assign conv_result = conv_active ? 14'h2d7b : 14'h1284;
  always_ff @(posedge core_clk) begin
    if (!rst_n || !rng_seed_req) begin
      seed_cnt <= 3'h0;
      rng_seed_done <= 1'b0;
    end else begin
      seed_cnt <= seed_cnt + 3'h1;
      rng_seed_done <= (seed_cnt == 3'h4);
    end
  end
endmodule // asc_fe_model
`default_nettype wire

// ---- tb.sv ----
// self-checking testbench for the converter sequence control
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic core_clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, dma_chan, rv;
  logic ext_pin = 1'b0, conv_start, conv_active, dma_all, rng_step;
  logic rng_seed_req, rng_seed_done, timer_hi = 1'b0;
  logic [3:0] mux_channel;
  logic [1:0] seq_ref, seq_dec, rng_mode;
  logic [13:0] conv_result, res_m;
  int err_count = 0, cmp_count = 0, n;
  asc_seq_ctrl u_asc_seq_ctrl (.core_clk(core_clk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .external_trigger_pin(ext_pin),
    .timer1_ch1_high(timer_hi), .conv_result(conv_result),
    .conv_start(conv_start), .conv_active(conv_active),
    .mux_channel(mux_channel), .seq_ref(seq_ref), .seq_dec(seq_dec),
    .dma_all(dma_all), .dma_chan(dma_chan), .rng_seed_done(rng_seed_done),
    .rng_mode(rng_mode), .rng_step(rng_step), .rng_seed_req(rng_seed_req));
  asc_fe_model u_asc_fe_model (.core_clk(core_clk), .rst_n(rst_n),
    .conv_active(conv_active), .rng_seed_req(rng_seed_req),
    .conv_result(conv_result), .rng_seed_done(rng_seed_done));
  initial begin
    forever #4 core_clk = ~core_clk;
  end
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic wait_done(output int cyc);
    cyc = 0;
    do begin
      @(posedge core_clk);
      #1 cyc++;
    end while (dma_all !== 1'b1 && cyc < 4000);
    check(dma_all, 1'b1);
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    rd(8'hb4, rv); check(rv, 8'h33);
    rd(8'hb5, rv); check(rv, 8'h10);
    rd(8'hbb, rv); check(rv, 8'h00);
    rd(8'hba, rv); check(rv, 8'h00);
    rd(8'h55, rv); check(rv, 8'h00);
    $display("test reset done");
  endtask
  task automatic t_rng_step();
    wr(8'hb4, 8'h37);
    #1 check(rng_mode, 2'h1);
    @(posedge core_clk);
    #1 check(rng_step, 1'b1);
    check(rng_mode, 2'h0);
    @(posedge core_clk);
    #1 check(rng_step, 1'b0);
    rd(8'hb4, rv); check(rv, 8'h33);
    wr(8'hb4, 8'h3f);
    repeat (2) @(posedge core_clk);
    #1 check(rng_mode, 2'h3);
    check(rng_step, 1'b0);
    wr(8'hb4, 8'h33);
    $display("test rng step done");
  endtask
  task automatic t_single(input logic [1:0] dec, input logic [13:0] mask);
    wr(8'hb5, {2'h0, dec, 4'hc});
    wr(8'hb4, 8'h73);
    check(seq_dec, dec);
    rd(8'hb4, rv); check(rv[6], 1'b1);
    wait_done(n);
    check(n >= ((64 << dec) + 16) * 6 - 8, 1'b1);
    check(n <= ((64 << dec) + 16) * 6 + 8, 1'b1);
    check(dma_chan, 8'h00);
    res_m = 14'h2d7b & mask;
    rd(8'hb4, rv); check(rv[7:6], 2'b10);
    rd(8'hbb, rv); check(rv, res_m[13:6]);
    rd(8'hb4, rv); check(rv[7], 1'b1);
    rd(8'hba, rv); check(rv, {res_m[5:0], 2'b00});
    rd(8'hb4, rv); check(rv[7], 1'b0);
    rd(8'hb5, rv); check(rv[3:0], 4'hc);
    $display("test single done");
  endtask
  task automatic t_sequence();
    logic [7:0] seen_ch;
    seen_ch = 8'h00;
    wr(8'hb4, 8'h3b);
    repeat (3) @(posedge core_clk);
    #1 check(rng_seed_req, 1'b0);
    check(rng_mode, 2'h2);
    wr(8'hb5, 8'hc1);
    wr(8'hb4, 8'h7b);
    @(posedge core_clk);
    #1 check(rng_seed_req, 1'b1);
    repeat (10) @(posedge core_clk);
    #1 check(rng_mode, 2'h0);
    check(rng_seed_req, 1'b0);
    wait_done(n);
    seen_ch = dma_chan;
    check(mux_channel, 4'h1);
    rd(8'hb5, rv); check(rv, 8'hc0);
    wait_done(n);
    seen_ch = seen_ch | dma_chan;
    check(seen_ch, 8'h03);
    check(seq_ref, 2'h3);
    rd(8'hb4, rv); check(rv[7:6], 2'b10);
    rd(8'hb5, rv); check(rv, 8'hc1);
    $display("test sequence done");
  endtask
  task automatic t_triggers();
    wr(8'hb5, 8'h0c);
    wr(8'hb4, 8'h03);
    @(posedge core_clk);
    ext_pin <= 1'b1;
    @(posedge core_clk);
    #1 check(conv_active, 1'b1);
    wait_done(n);
    repeat (3) @(posedge core_clk);
    #1 check(conv_active, 1'b0);
    @(posedge core_clk);
    ext_pin <= 1'b0;
    wr(8'hb4, 8'h23);
    @(posedge core_clk);
    timer_hi <= 1'b1;
    @(posedge core_clk);
    #1 check(conv_active, 1'b1);
    @(posedge core_clk);
    timer_hi <= 1'b0;
    wait_done(n);
    wr(8'hb4, 8'h13);
    wait_done(n);
    @(posedge core_clk);
    #1 check(conv_active, 1'b1);
    wr(8'hb4, 8'h33);
    wait_done(n);
    @(posedge core_clk);
    #1 check(conv_active, 1'b0);
    $display("test triggers done");
  endtask
  initial begin
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    t_reset();
    t_rng_step();
    t_single(2'h0, asc_pkg::ASC_MASK_8B);
    t_single(2'h2, asc_pkg::ASC_MASK_12B);
    t_sequence();
    t_triggers();
    report_and_stop();
  end
  initial begin
    #200us;
    err_count++;
    report_and_stop();
  end
endmodule // tb
`default_nettype wire
